// ### rtl/pg_pkg.sv
// Constants for the eight-pin general-purpose port with alternate functions.
// Assumes a plain register port whose address is the full 32-bit byte address.
// What this block does
// - Registers decode at base 0x400C_0600; offsets are relative to it.
// - Pin data register at 0x0000 holds bits 7..0; bits 31..8 read zero.
// - Output control at 0x0004: bit 1 enables that pin's driver, 0 disables.
// - Function one at 0x0008 routes external bus data line 8+n to pin n.
// - Function two at 0x000C: bits 7..2 motor phases, bit 1 stop; bit 0 zero.
// - Function three at 0x0010: serial 7..4, timer outs, emergency, input.
// - Function four at 0x0014: bit 3 linked timer out, bit 2 in; rest zero.
// - Open-drain control at 0x0028: 0 push-pull, 1 open-drain per pin.
// - Pull-up control at 0x002C: 1 enables that pin's pull-up.
// - Pull-down control at 0x0030: 1 enables that pin's pull-down.
// - Input control at 0x0038: 1 enables that pin's input buffer.
// - All registers reset to zero: port use, no drive, no input, no pulls.
package pg_pkg;

    // ==========================================================
    // Bus geometry
    localparam int          PG_PINS      = 8;
    localparam int          PG_DW        = 32;
    localparam int          PG_AW        = 32;
    localparam int          PG_OFS_HI    = 5;
    localparam logic [31:0] PG_BASE_ADDR = 32'h400C_0600;

    // ==========================================================
    // Register offsets
    localparam logic [5:0] PG_OFS_DATA = 6'h00;
    localparam logic [5:0] PG_OFS_OEN  = 6'h04;
    localparam logic [5:0] PG_OFS_FS1  = 6'h08;
    localparam logic [5:0] PG_OFS_FS2  = 6'h0C;
    localparam logic [5:0] PG_OFS_FS3  = 6'h10;
    localparam logic [5:0] PG_OFS_FS4  = 6'h14;
    localparam logic [5:0] PG_OFS_OD   = 6'h28;
    localparam logic [5:0] PG_OFS_PU   = 6'h2C;
    localparam logic [5:0] PG_OFS_PD   = 6'h30;
    localparam logic [5:0] PG_OFS_IE   = 6'h38;

    // ==========================================================
    // Reset value and writable bits of the function registers
    localparam logic [7:0] PG_RST      = 8'h00;
    localparam logic [7:0] PG_MASK_ALL = 8'hFF;
    localparam logic [7:0] PG_MASK_FS2 = 8'hFE;
    localparam logic [7:0] PG_MASK_FS4 = 8'h0C;

    // Pins whose alternate function drives the pin unconditionally
    localparam logic [7:0] PG_FS2_DRV  = 8'hFC;
    localparam logic [7:0] PG_FS4_DRV  = 8'h08;

    // ==========================================================
    // Pin positions of alternate functions
    localparam int PG_BIT_STOP   = 1;
    localparam int PG_BIT_FRAME  = 7;
    localparam int PG_BIT_SDI    = 6;
    localparam int PG_BIT_SDO    = 5;
    localparam int PG_BIT_SCLK   = 4;
    localparam int PG_BIT_MTA    = 3;
    localparam int PG_BIT_MTB    = 2;
    localparam int PG_BIT_TEMG   = 1;
    localparam int PG_BIT_MTIN   = 0;
    localparam int PG_BIT_LTOUT  = 3;
    localparam int PG_BIT_LTIN   = 2;

endpackage : pg_pkg

// ### rtl/pg_port_top.sv
// Eight-pin port: register file, per-pin function mux and pad controls.
// Assumes pads resolve level from pin_out/pin_oe and apply the pull outputs;
// peripheral signals are on ref_clk, pin inputs are asynchronous.
module pg_port_top
    import pg_pkg::*;
(
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    // Register port
    input  wire logic [PG_AW-1:0]   reg_addr,
    input  wire logic [PG_DW-1:0]   reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [PG_DW-1:0]   reg_rdata,
    // Pads
    input  wire logic [PG_PINS-1:0] pin_in,
    output logic      [PG_PINS-1:0] pin_out,
    output logic      [PG_PINS-1:0] pin_oe,
    output logic      [PG_PINS-1:0] pin_pull_up,
    output logic      [PG_PINS-1:0] pin_pull_down,
    output logic      [PG_PINS-1:0] pin_input_en,
    // External bus data lines 15..8
    input  wire logic [PG_PINS-1:0] ebus_data_out,
    input  wire logic [PG_PINS-1:0] ebus_data_oe,
    output logic      [PG_PINS-1:0] ebus_data_in,
    // Motor drive phases and emergency stop
    input  wire logic               phase_u_high_out,
    input  wire logic               phase_u_low_out,
    input  wire logic               phase_v_high_out,
    input  wire logic               phase_v_low_out,
    input  wire logic               phase_w_high_out,
    input  wire logic               phase_w_low_out,
    output logic                    emergency_stop_in_n,
    // Synchronous serial
    input  wire logic               sync_serial_frame_out,
    input  wire logic               sync_serial_frame_oe,
    output logic                    sync_serial_frame,
    output logic                    sync_serial_data_in,
    input  wire logic               sync_serial_data_out,
    input  wire logic               sync_serial_clock_out,
    input  wire logic               sync_serial_clock_oe,
    output logic                    sync_serial_clock,
    // Motor timer and linked timer
    input  wire logic               motor_timer_out_a,
    input  wire logic               motor_timer_out_b,
    output logic                    timer_emergency_in_n,
    output logic                    motor_timer_in,
    input  wire logic               linked_timer_out,
    output logic                    linked_timer_in
);

    // ==========================================================
    // Register storage
    logic [PG_PINS-1:0] pin_data;
    logic [PG_PINS-1:0] output_enable;
    logic [PG_PINS-1:0] function_select_one;
    logic [PG_PINS-1:0] function_select_two;
    logic [PG_PINS-1:0] function_select_three;
    logic [PG_PINS-1:0] function_select_four;
    logic [PG_PINS-1:0] open_drain_select;
    logic [PG_PINS-1:0] pull_up_enable;
    logic [PG_PINS-1:0] pull_down_enable;
    logic [PG_PINS-1:0] input_enable;

    // ==========================================================
    // Address decode
    wire logic                 base_hit;
    wire logic [PG_OFS_HI:0]   ofs;
    wire logic                 hit_data;
    wire logic                 hit_oen;
    wire logic                 hit_fs1;
    wire logic                 hit_fs2;
    wire logic                 hit_fs3;
    wire logic                 hit_fs4;
    wire logic                 hit_od;
    wire logic                 hit_pu;
    wire logic                 hit_pd;
    wire logic                 hit_ie;
    wire logic [PG_PINS-1:0]   wbyte;

    // Upper address bits select this port's window
    assign base_hit = reg_addr[PG_AW-1:PG_OFS_HI+1]
                   == PG_BASE_ADDR[PG_AW-1:PG_OFS_HI+1];
    assign ofs      = reg_addr[PG_OFS_HI:0];
    assign wbyte    = reg_wdata[PG_PINS-1:0];

    // Reserved offsets match nothing, so they write nowhere and read zero
    assign hit_data = base_hit && (ofs == PG_OFS_DATA);
    assign hit_oen  = base_hit && (ofs == PG_OFS_OEN);
    assign hit_fs1  = base_hit && (ofs == PG_OFS_FS1);
    assign hit_fs2  = base_hit && (ofs == PG_OFS_FS2);
    assign hit_fs3  = base_hit && (ofs == PG_OFS_FS3);
    assign hit_fs4  = base_hit && (ofs == PG_OFS_FS4);
    assign hit_od   = base_hit && (ofs == PG_OFS_OD);
    assign hit_pu   = base_hit && (ofs == PG_OFS_PU);
    assign hit_pd   = base_hit && (ofs == PG_OFS_PD);
    assign hit_ie   = base_hit && (ofs == PG_OFS_IE);

    // ==========================================================
    // Register writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_data              <= PG_RST;
            output_enable         <= PG_RST;
            function_select_one   <= PG_RST;
            function_select_two   <= PG_RST;
            function_select_three <= PG_RST;
            function_select_four  <= PG_RST;
            open_drain_select     <= PG_RST;
            pull_up_enable        <= PG_RST;
            pull_down_enable      <= PG_RST;
            input_enable          <= PG_RST;
        end else if (reg_wr) begin
            if (hit_data) begin
                pin_data <= wbyte;
            end else if (hit_oen) begin
                output_enable <= wbyte;
            end else if (hit_fs1) begin
                function_select_one <= wbyte & PG_MASK_ALL;
            end else if (hit_fs2) begin
                function_select_two <= wbyte & PG_MASK_FS2;
            end else if (hit_fs3) begin
                function_select_three <= wbyte & PG_MASK_ALL;
            end else if (hit_fs4) begin
                function_select_four <= wbyte & PG_MASK_FS4;
            end else if (hit_od) begin
                open_drain_select <= wbyte;
            end else if (hit_pu) begin
                pull_up_enable <= wbyte;
            end else if (hit_pd) begin
                pull_down_enable <= wbyte;
            end else if (hit_ie) begin
                input_enable <= wbyte;
            end
        end
    end

    // ==========================================================
    // Pin input synchroniser
    logic [PG_PINS-1:0] pin_meta;
    logic [PG_PINS-1:0] pin_sync;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_meta <= PG_RST;
            pin_sync <= PG_RST;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Disabled input buffers read as zero
    wire logic [PG_PINS-1:0] pin_level;
    assign pin_level = pin_sync & input_enable;

    // ==========================================================
    // Read data
    wire logic [PG_PINS-1:0] rd_byte;
    wire logic [PG_DW-1:0]   next_rdata;

    assign rd_byte =
        hit_data ? pin_level             :
        hit_oen  ? output_enable         :
        hit_fs1  ? function_select_one   :
        hit_fs2  ? function_select_two   :
        hit_fs3  ? function_select_three :
        hit_fs4  ? function_select_four  :
        hit_od   ? open_drain_select     :
        hit_pu   ? pull_up_enable        :
        hit_pd   ? pull_down_enable      :
        hit_ie   ? input_enable          : PG_RST;

    // Upper bits always zero
    assign next_rdata = {{(PG_DW-PG_PINS){1'b0}}, rd_byte};

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

    // ==========================================================
    // Function selection with fixed priority
    wire logic [PG_PINS-1:0] sel_one;
    wire logic [PG_PINS-1:0] sel_two;
    wire logic [PG_PINS-1:0] sel_three;
    wire logic [PG_PINS-1:0] sel_four;
    wire logic [PG_PINS-1:0] sel_port;

    // A lower register masks all higher ones, so one source per pin
    assign sel_one   = function_select_one;
    assign sel_two   = function_select_two & ~sel_one;
    assign sel_three = function_select_three
                     & ~(function_select_one | function_select_two);
    assign sel_four  = function_select_four
                     & ~(function_select_one | function_select_two
                       | function_select_three);
    assign sel_port  = ~(sel_one | sel_two | sel_three | sel_four);

    // ==========================================================
    // Alternate output values and drive requests
    wire logic [PG_PINS-1:0] val_two;
    wire logic [PG_PINS-1:0] val_three;
    wire logic [PG_PINS-1:0] req_three;
    wire logic [PG_PINS-1:0] val_four;

    assign val_two   = {phase_u_high_out, phase_u_low_out,
                        phase_v_high_out, phase_v_low_out,
                        phase_w_high_out, phase_w_low_out,
                        2'b00};
    assign val_three = {sync_serial_frame_out, 1'b0,
                        sync_serial_data_out, sync_serial_clock_out,
                        motor_timer_out_a, motor_timer_out_b,
                        2'b00};
    assign req_three = {sync_serial_frame_oe, 1'b0,
                        1'b1, sync_serial_clock_oe,
                        2'b11, 2'b00};
    assign val_four  = {4'h0, linked_timer_out, 3'h0};

    wire logic [PG_PINS-1:0] next_value;
    wire logic [PG_PINS-1:0] next_req;
    wire logic [PG_PINS-1:0] next_drive;
    wire logic [PG_PINS-1:0] next_oe;

    assign next_value = (sel_one   & ebus_data_out)
                      | (sel_two   & val_two)
                      | (sel_three & val_three)
                      | (sel_four  & val_four)
                      | (sel_port  & pin_data);
    assign next_req   = (sel_one   & ebus_data_oe)
                      | (sel_two   & PG_FS2_DRV)
                      | (sel_three & req_three)
                      | (sel_four  & PG_FS4_DRV)
                      | sel_port;

    // Output control gates every source, port or alternate
    assign next_drive = next_req & output_enable;

    // Open drain only pulls low; a high releases the pin
    assign next_oe    = next_drive & (~open_drain_select | ~next_value);

    // ==========================================================
    // Pad outputs, registered for clean pad timing
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_out       <= PG_RST;
            pin_oe        <= PG_RST;
            pin_pull_up   <= PG_RST;
            pin_pull_down <= PG_RST;
            pin_input_en  <= PG_RST;
        end else begin
            pin_out       <= next_value;
            pin_oe        <= next_oe;
            pin_pull_up   <= pull_up_enable;
            pin_pull_down <= pull_down_enable;
            pin_input_en  <= input_enable;
        end
    end

    // ==========================================================
    // Inputs towards the peripherals
    // Emergency lines are active low: a deselected pin reads as idle high
    wire logic [PG_PINS-1:0] next_ebus_in;
    wire logic               next_stop_n;
    wire logic               next_temg_n;

    assign next_ebus_in = sel_one & pin_level;
    assign next_stop_n  = ~(sel_two[PG_BIT_STOP]
                          & input_enable[PG_BIT_STOP]
                          & ~pin_sync[PG_BIT_STOP]);
    assign next_temg_n  = ~(sel_three[PG_BIT_TEMG]
                          & input_enable[PG_BIT_TEMG]
                          & ~pin_sync[PG_BIT_TEMG]);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ebus_data_in         <= PG_RST;
            emergency_stop_in_n  <= 1'b1;
            timer_emergency_in_n <= 1'b1;
            sync_serial_frame    <= 1'b0;
            sync_serial_data_in  <= 1'b0;
            sync_serial_clock    <= 1'b0;
            motor_timer_in       <= 1'b0;
            linked_timer_in      <= 1'b0;
        end else begin
            ebus_data_in         <= next_ebus_in;
            emergency_stop_in_n  <= next_stop_n;
            timer_emergency_in_n <= next_temg_n;
            sync_serial_frame    <= sel_three[PG_BIT_FRAME]
                                  & pin_level[PG_BIT_FRAME];
            sync_serial_data_in  <= sel_three[PG_BIT_SDI]
                                  & pin_level[PG_BIT_SDI];
            sync_serial_clock    <= sel_three[PG_BIT_SCLK]
                                  & pin_level[PG_BIT_SCLK];
            motor_timer_in       <= sel_three[PG_BIT_MTIN]
                                  & pin_level[PG_BIT_MTIN];
            linked_timer_in      <= sel_four[PG_BIT_LTIN]
                                  & pin_level[PG_BIT_LTIN];
        end
    end

endmodule : pg_port_top

// ### tb/pg_port_asserts.sv
// Concurrent checks on the port block's register and pad ports.
// Assumes the bind below attaches it to every pg_port_top instance.
module pg_port_asserts
    import pg_pkg::*;
(
    // Clock and reset
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    // Register port
    input wire logic [PG_AW-1:0]   reg_addr,
    input wire logic [PG_DW-1:0]   reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [PG_DW-1:0]   reg_rdata,
    // Pads and bus lines
    input wire logic [PG_PINS-1:0] pin_out,
    input wire logic [PG_PINS-1:0] pin_oe,
    input wire logic [PG_PINS-1:0] pin_pull_up,
    input wire logic [PG_PINS-1:0] pin_pull_down,
    input wire logic [PG_PINS-1:0] pin_input_en,
    input wire logic [PG_PINS-1:0] ebus_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Decode and shadows of the registers that steer the pads
    wire       in_win = reg_addr[31:6] == PG_BASE_ADDR[31:6];
    wire [5:0] ofs    = reg_addr[5:0];
    wire       rsv    = in_win && (ofs inside {6'h18, 6'h1C, 6'h20,
                                               6'h24, 6'h34});
    wire       wr_oen = reg_wr && in_win && ofs == PG_OFS_OEN;
    wire       wr_fs1 = reg_wr && in_win && ofs == PG_OFS_FS1;
    wire       wr_od  = reg_wr && in_win && ofs == PG_OFS_OD;
    wire       wr_pu  = reg_wr && in_win && ofs == PG_OFS_PU;
    wire       wr_pd  = reg_wr && in_win && ofs == PG_OFS_PD;
    wire       wr_ie  = reg_wr && in_win && ofs == PG_OFS_IE;
    logic [7:0] oen_sh;
    logic [7:0] fs1_sh;
    logic [7:0] od_sh;
    always_ff @(posedge ref_clk) begin
        oen_sh <= sys_rst ? 8'h00 : wr_oen ? reg_wdata[7:0] : oen_sh;
        fs1_sh <= sys_rst ? 8'h00 : wr_fs1 ? reg_wdata[7:0] : fs1_sh;
        od_sh  <= sys_rst ? 8'h00 : wr_od ? reg_wdata[7:0] : od_sh;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Properties
    upper_zero_a: assert property (reg_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    reserved_read_a: assert property (reg_rd && rsv |=> reg_rdata == 0)
        else $error("reserved offset read not zero");
    foreign_read_a: assert property (reg_rd && !in_win |=> !reg_rdata)
        else $error("read outside window not zero");
    fn_two_read_a: assert property (
        reg_rd && in_win && ofs == PG_OFS_FS2 |=> !reg_rdata[0])
        else $error("function two bit 0 not zero");
    fn_four_read_a: assert property (
        reg_rd && in_win && ofs == PG_OFS_FS4 |=> reg_rdata[7:0] ==
        (reg_rdata[7:0] & PG_MASK_FS4))
        else $error("function four unused bits not zero");
    pull_up_copy_a: assert property (
        wr_pu ##1 !wr_pu |=> pin_pull_up == $past(reg_wdata[7:0], 2))
        else $error("pull-up output does not follow register");
    pull_down_copy_a: assert property (
        wr_pd ##1 !wr_pd |-> ##1 pin_pull_down == $past(reg_wdata[7:0], 2))
        else $error("pull-down output does not follow register");
    input_copy_a: assert property (
        wr_ie ##1 !wr_ie ##1 1'b1 |->
        pin_input_en == $past(reg_wdata[7:0], 2))
        else $error("input enable output does not follow register");
    drive_gate_a: assert property ((pin_oe & ~$past(oen_sh)) == 8'h00)
        else $error("pad driven with output control off");
    open_drain_a: assert property (
        (pin_oe & pin_out & $past(od_sh)) == 8'h00)
        else $error("open-drain pad drives high");
    fn_one_route_a: assert property (
        ((pin_out ^ $past(ebus_data_out)) & $past(fs1_sh)) == 8'h00)
        else $error("bus data line not routed to pad");
    reset_idle_a: assert property ($fell(sys_rst) |->
        (pin_oe | pin_pull_up | pin_pull_down | pin_input_en) == 8'h00)
        else $error("pad controls not idle after reset");
endmodule : pg_port_asserts

bind pg_port_top pg_port_asserts pg_port_asserts_i (
    .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down,
    .pin_input_en, .ebus_data_out
);

// ### tb/pg_board.sv
// Board model: pads, pulls and an external driver the bench steers.
// Assumes ref_clk paces the toggling of pads that nothing holds.
module pg_board
    import pg_pkg::*;
(
    // Clock
    input  wire logic               ref_clk,
    // Block side
    input  wire logic [PG_PINS-1:0] pin_out,
    input  wire logic [PG_PINS-1:0] pin_oe,
    input  wire logic [PG_PINS-1:0] pin_pull_up,
    input  wire logic [PG_PINS-1:0] pin_pull_down,
    output logic      [PG_PINS-1:0] pin_in,
    // External driver
    input  wire logic [PG_PINS-1:0] ext_val,
    input  wire logic [PG_PINS-1:0] ext_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Pad resolution
    logic [PG_PINS-1:0] last = 8'h00;
    // A pad held by nobody toggles so a stale level never looks driven
    wire  [PG_PINS-1:0] held = pin_oe | ext_oe | pin_pull_up | pin_pull_down;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                  | (~pin_oe & ~ext_oe & pin_pull_up) | (~held & ~last);
    always @(posedge ref_clk) last <= pin_in;
endmodule : pg_board

// ### tb/tb_top.sv
// Self-checking bench for the eight-pin port block.
// Assumes the board model and the bound checker are compiled beside it.
module tb_top
    import pg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Signals
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down;
    logic [7:0]  pin_input_en, ebus_data_in, ext_val = 8'h0, ext_oe = 8'h0;
    logic [7:0]  ebus_data_out = 8'h0, ebus_data_oe = 8'h0, f3 = 8'h0;
    logic [5:0]  ph = 6'h0;
    logic        emergency_stop_in_n, sync_serial_frame, sync_serial_clock;
    logic        sync_serial_data_in, timer_emergency_in_n;
    logic        motor_timer_in, linked_timer_in;
    logic [31:0] base = PG_BASE_ADDR;
    int          errors = 0, samples_checked = 0, cycles = 0;
    logic [5:0]  ofs_tab [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10,
                                  6'h14, 6'h28, 6'h2C, 6'h30, 6'h38};
    logic [7:0]  msk_tab [10] = '{8'h00, 8'hFF, 8'hFF, 8'hFE, 8'hFF,
                                  8'h0C, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [5:0]  rsv_tab [5] = '{6'h18, 6'h1C, 6'h20, 6'h24, 6'h34};

    pg_port_top pg_port_top_i (
        .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_in, .pin_out, .pin_oe, .pin_pull_up,
        .pin_pull_down, .pin_input_en, .ebus_data_out, .ebus_data_oe,
        .ebus_data_in, .phase_u_high_out(ph[5]), .phase_u_low_out(ph[4]),
        .phase_v_high_out(ph[3]), .phase_v_low_out(ph[2]),
        .phase_w_high_out(ph[1]), .phase_w_low_out(ph[0]),
        .emergency_stop_in_n, .sync_serial_frame_out(f3[7]),
        .sync_serial_frame_oe(f3[6]), .sync_serial_frame,
        .sync_serial_data_in, .sync_serial_data_out(f3[5]),
        .sync_serial_clock_out(f3[4]), .sync_serial_clock_oe(f3[3]),
        .sync_serial_clock, .motor_timer_out_a(f3[2]),
        .motor_timer_out_b(f3[1]), .timer_emergency_in_n, .motor_timer_in,
        .linked_timer_out(f3[0]), .linked_timer_in
    );
    pg_board pg_board_i (
        .ref_clk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .pin_in,
        .ext_val, .ext_oe
    );

    always #5 ref_clk = ~ref_clk;

    // ==========================================================
    // Tasks
    task automatic conclude();
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] ofs, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= base + {26'h0, ofs};
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] ofs, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= base + {26'h0, ofs};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_n

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end

    // ==========================================================
    // Scenarios
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1;
        chk({pin_oe, pin_pull_up, pin_pull_down, pin_input_en}, 0);
        chk({emergency_stop_in_n, timer_emergency_in_n}, 2'b11);
        foreach (ofs_tab[i]) begin
            rd(ofs_tab[i], 32'h0);
            wr(ofs_tab[i], 32'hFFFF_FFFF);
            rd(ofs_tab[i], {24'h0, msk_tab[i]});
            wr(ofs_tab[i], 32'h0);
        end
        foreach (rsv_tab[i]) begin
            wr(rsv_tab[i], 32'hFFFF_FFFF);
            rd(rsv_tab[i], 32'h0);
        end
        base = PG_BASE_ADDR + 32'h100;
        wr(6'h04, 32'hFF);
        rd(6'h04, 32'h0);
        base = PG_BASE_ADDR;
        rd(6'h04, 32'h0);
        // Port use, pulls, then open drain releasing the high pins
        wr(6'h04, 32'hFF);
        wr(6'h00, 32'hA5);
        wr(6'h2C, 32'h0F);
        wr(6'h30, 32'hF0);
        wr(6'h38, 32'hFF);
        wait_n(2);
        chk({pin_out, pin_oe, pin_pull_up, pin_pull_down},
            32'hA5FF_0FF0);
        rd(6'h00, 32'hA5);
        wr(6'h28, 32'hFF);
        wait_n(2);
        chk({pin_out, pin_oe}, 16'hA55A);
        rd(6'h00, 32'h05);
        wr(6'h04, 32'h0);
        ext_oe  <= 8'hFF;
        ext_val <= 8'h3C;
        wr(6'h38, 32'h0F);
        wait_n(3);
        rd(6'h00, 32'h0C);
        // Bus data lines win over function two on the same pins
        ext_oe <= 8'h00;
        wr(6'h38, 32'hFF);
        wr(6'h28, 32'h0);
        wr(6'h04, 32'hFF);
        ebus_data_out <= 8'h96;
        ebus_data_oe  <= 8'hF0;
        wr(6'h08, 32'hFF);
        wr(6'h0C, 32'hFF);
        wait_n(4);
        chk({pin_out, pin_oe, ebus_data_in}, 24'h96F09F);
        // Motor phases and emergency stop
        ph      <= 6'b101100;
        ext_oe  <= 8'h02;
        ext_val <= 8'h00;
        wr(6'h08, 32'h0);
        wait_n(4);
        chk({pin_out[7:2], pin_oe[7:2], emergency_stop_in_n,
             timer_emergency_in_n}, {6'b101100, 6'h3F, 2'b01});
        // Serial and motor timer, clock pad left to the board
        f3      <= 8'hD4;
        ext_oe  <= 8'h53;
        ext_val <= 8'h41;
        wr(6'h0C, 32'h0);
        wr(6'h10, 32'hFF);
        wait_n(4);
        chk({pin_oe[7:2], pin_out[7], pin_out[5], pin_out[3], pin_out[2],
             sync_serial_frame, sync_serial_data_in, sync_serial_clock,
             timer_emergency_in_n, motor_timer_in, emergency_stop_in_n},
            {6'b101011, 4'b1010, 6'b110011});
        f3      <= 8'h01;
        ext_oe  <= 8'h04;
        ext_val <= 8'h04;
        wr(6'h10, 32'h0);
        wr(6'h14, 32'hFF);
        wait_n(4);
        chk({pin_oe[3:2], pin_out[3], linked_timer_in}, 4'b1011);
        conclude();
    end
endmodule : tb_top
